// ==== rtl/event_flags_pkg.sv ====
package event_flags_pkg;

  // Register address of the event flag register
  localparam logic [7:0] FLAGS_ADDR = 8'h17;
  // Register address of the second control register (select bit lives here)
  localparam logic [7:0] CTRL2_ADDR = 8'h15;
  // Register address of the interrupt mask register
  localparam logic [7:0] MASK_ADDR = 8'h16;

  // Flag bit positions
  localparam int GO_AHEAD_BIT = 7;
  localparam int RX_END_BIT = 6;
  localparam int TX_DONE_BIT = 5;
  localparam int RX_LAST_BIT = 4;
  localparam int TX_LOW_BIT = 3;
  localparam int ABORT_UNDER_BIT = 2;
  localparam int RX_HIGH_BIT = 1;
  localparam int RX_OVF_BIT = 0;
  // Position of the abort-or-underrun select in control register 2
  localparam int SEL_BIT = 7;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;

  // Least received bits before an abort counts
  localparam logic [4:0] ABORT_MIN_BITS = 5'h1A;

  // Event pulses from receiver, transmitter and FIFOs
  typedef struct packed {
    logic go_ahead;      // Go-ahead pattern seen
    logic rx_tag_wr;     // Packet-end tagged byte written to rx FIFO
    logic tx_done;       // Closing flag sent or packet aborted
    logic rx_last_next;  // Next rx FIFO byte ends a packet
    logic tx_below_low;  // Tx FIFO dropped below low threshold
    logic rx_abort;      // Abort sequence received
    logic tx_empty_rd;   // Transmitter fetched from empty tx FIFO
    logic rx_above_high; // Rx FIFO rose above full threshold
    logic rx_full_wr;    // Receiver wrote to full rx FIFO
    logic rx_flag;       // Flag sequence detected
    logic rx_bit;        // One packet bit received
    logic rx_empty_rd;   // Host read of empty rx FIFO
  } events_t;

  // Whole state of the flag block
  typedef struct packed {
    logic [7:0] flags;   // Sticky event flags
    logic [7:0] mask;    // Interrupt mask
    logic [7:0] ctrl2;   // Control register 2
    logic [4:0] bits;    // Bits of current packet, saturating
    logic rx_en;         // Receiver enabled
    logic irq_n;         // Interrupt pin, active low
    logic [7:0] rdata;   // Read data register
    logic flag_prev;     // Flag level last cycle, for edge detect
  } state_t;

endpackage

// ==== rtl/event_sync.sv ====
`timescale 1ns/1ns
// Two-stage synchroniser for the flag wire from the receiver
module event_sync
  import event_flags_pkg::*;
(
  input wire logic clk_in,  // System clock
  input wire logic rst_in,  // Async reset, high
  input wire logic d_in,    // Asynchronous level
  output logic q_out        // Synchronised level
);
  logic [1:0] sync_ff; // Stage 0 feeds only stage 1

  // Two flops; nothing reads the first but the second
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync_ff <= 2'h0;
    end
    else
    begin
      sync_ff <= {sync_ff[0], d_in};
    end
  end

  assign q_out = sync_ff[1];
endmodule

// ==== rtl/hdlc_event_status_flags.sv ====
`timescale 1ns/1ns
// Contract
// (R1) Go-ahead detection sets flag bit 7
// (R2) Packet-end byte into rx FIFO sets bit 6
// (R3) Closing flag sent or abort sets bit 5
// (R4) Last packet byte next sets bit 4
// (R5) Reading empty rx FIFO sets bit 4
// (R6) Tx FIFO below low threshold sets bit 3
// (R7) Select low: abort after 26 bits sets 2
// (R8) Select high: tx underrun sets bit 2
// (R9) Rx FIFO above full threshold sets bit 1
// (R10) Write to full 128-byte FIFO sets 0; code sets it only while rx_en is high
// (R11) Overflow disables the receiver
// (R12) Next flag re-enables receiver after overflow
// (R13) Reading the register clears all flags
// (R14) Masked flags recorded but no interrupt
// (R15) Mask register clears on reset
// (R16) Control 2 bit 7 selects underrun or abort
// (R17) Reset clears flags; set beats clearing read
// (R18) Flags latch pulses until cleared
module hdlc_event_status_flags
  import event_flags_pkg::*;
(
  input wire logic clk_in,          // System clock, 10 MHz
  input wire logic rst_in,          // Async reset, high
  input wire logic [7:0] addr_in,   // Register address
  input wire logic rd_in,           // Register read strobe, one cycle
  input wire logic wr_in,           // Register write strobe, one cycle
  input wire logic [7:0] wdata_in,  // Write data
  input wire events_t ev_in,        // Event pulses, same clock
  input wire logic flag_pin_in,     // Raw flag-detect level, async
  output logic [7:0] rdata_out,     // Registered read data
  output logic irq_n_out,           // Interrupt, active low
  output logic rx_en_out            // Receiver enable
);
  state_t cur_ff;   // Registered state
  state_t nxt_st;   // Next state
  logic flag_sync;  // Synchronised flag level
  logic [7:0] set_v; // Set terms this cycle
  logic flags_rd;   // Host reads the flag register

  // Flag pin arrives from another domain; two flops before any use
  event_sync i_event_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(flag_pin_in),
    .q_out(flag_sync)
  );

  // This decode feeds the clear only; read data decodes rd_in and addr_in in its own case
  assign flags_rd = rd_in && (addr_in == FLAGS_ADDR);

  // Next-state logic
  always_comb
  begin
    nxt_st = cur_ff;
    set_v = 8'h00;
    // (R1) Go-ahead set
    set_v[GO_AHEAD_BIT] = ev_in.go_ahead;
    // (R2) Packet end written
    set_v[RX_END_BIT] = ev_in.rx_tag_wr;
    // (R3) Transmit done
    set_v[TX_DONE_BIT] = ev_in.tx_done;
    // (R4) (R5) Last byte or empty read
    set_v[RX_LAST_BIT] = ev_in.rx_last_next | ev_in.rx_empty_rd;
    // (R6) Tx FIFO low
    set_v[TX_LOW_BIT] = ev_in.tx_below_low;
    // (R16) (R7) (R8) Abort or underrun selection
    if (cur_ff.ctrl2[SEL_BIT])
    begin
      set_v[ABORT_UNDER_BIT] = ev_in.tx_empty_rd;
    end
    else
    begin
      // Short frames are noise; abort ignored below threshold
      set_v[ABORT_UNDER_BIT] = ev_in.rx_abort && (cur_ff.bits >= ABORT_MIN_BITS);
    end
    // (R9) Rx FIFO high
    set_v[RX_HIGH_BIT] = ev_in.rx_above_high;
    // (R10) Overflow only counted while receiving
    set_v[RX_OVF_BIT] = ev_in.rx_full_wr && cur_ff.rx_en;

    // Packet bit count, restarted by flags and aborts
    if (ev_in.rx_flag || ev_in.rx_abort)
    begin
      nxt_st.bits = 5'h00;
    end
    else if (ev_in.rx_bit && (cur_ff.bits != 5'h1F))
    begin
      nxt_st.bits = cur_ff.bits + 5'h01;
    end

    // (R13) (R17) (R18) Read clears, sets win, flags sticky
    if (flags_rd)
    begin
      nxt_st.flags = set_v;
    end
    else
    begin
      nxt_st.flags = cur_ff.flags | set_v;
    end

    // Edge detect looks at the second stage only
    nxt_st.flag_prev = flag_sync;
    // (R12) Flag sequence re-enables the receiver
    if (flag_sync && !cur_ff.flag_prev)
    begin
      nxt_st.rx_en = 1'b1;
    end
    // (R11) Overflow disables it, stronger than re-enable
    if (set_v[RX_OVF_BIT])
    begin
      nxt_st.rx_en = 1'b0;
    end

    // Register writes
    if (wr_in && (addr_in == MASK_ADDR))
    begin
      nxt_st.mask = wdata_in;
    end
    if (wr_in && (addr_in == CTRL2_ADDR))
    begin
      nxt_st.ctrl2 = wdata_in;
    end

    // Registered read data; unmapped reads give zero
    if (rd_in)
    begin
      unique case (addr_in)
        FLAGS_ADDR: nxt_st.rdata = cur_ff.flags;
        MASK_ADDR: nxt_st.rdata = cur_ff.mask;
        CTRL2_ADDR: nxt_st.rdata = cur_ff.ctrl2;
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // (R14) Only unmasked flags pull the pin low
    nxt_st.irq_n = ~|(nxt_st.flags & nxt_st.mask);
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // (R15) (R17) Mask and flags clear
      // Flag pin idles low, so a low history gives no false edge
      cur_ff <= '{flags: FLAGS_RST, mask: MASK_RST, ctrl2: CTRL2_RST, bits: 5'h00,
                  rx_en: 1'b1, irq_n: 1'b1, rdata: 8'h00, flag_prev: 1'b0};
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  assign rdata_out = cur_ff.rdata;
  assign irq_n_out = cur_ff.irq_n;
  assign rx_en_out = cur_ff.rx_en;

  // (R13) Clearing read leaves only fresh events
  a_read_clears: assert property (@(posedge clk_in) disable iff (rst_in) // (R13)
    flags_rd |=> ((cur_ff.flags & ~$past(set_v)) == 8'h00))
    else $error("flags not cleared by read");

  // (R17) Event in read cycle survives
  a_set_wins: assert property (@(posedge clk_in) disable iff (rst_in) // (R17)
    (flags_rd && ev_in.go_ahead) |=> cur_ff.flags[GO_AHEAD_BIT])
    else $error("event lost on read");

  // (R18) Flags hold without read
  a_flags_hold: assert property (@(posedge clk_in) disable iff (rst_in) // (R18)
    !flags_rd |=> ((cur_ff.flags & $past(cur_ff.flags)) == $past(cur_ff.flags)))
    else $error("flag dropped without read");

  // (R11) Overflow stops receiver
  a_ovf_disable: assert property (@(posedge clk_in) disable iff (rst_in) // (R11)
    (ev_in.rx_full_wr && rx_en_out) |=> (!rx_en_out && cur_ff.flags[RX_OVF_BIT]))
    else $error("overflow did not stop receiver");

  // (R14) Interrupt pin follows masked flags
  a_irq_mask: assert property (@(posedge clk_in) disable iff (rst_in) // (R14)
    irq_n_out == ~|(cur_ff.flags & cur_ff.mask))
    else $error("interrupt pin wrong");

  // (R7) Early abort ignored
  a_short_abort: assert property (@(posedge clk_in) disable iff (rst_in) // (R7)
    (ev_in.rx_abort && !cur_ff.ctrl2[SEL_BIT] && cur_ff.bits < ABORT_MIN_BITS
     && !cur_ff.flags[ABORT_UNDER_BIT]) |=> !cur_ff.flags[ABORT_UNDER_BIT])
    else $error("short abort flagged");

  // (R7) Abort after enough bits is flagged
  a_long_abort: assert property (@(posedge clk_in) disable iff (rst_in) // (R7)
    (ev_in.rx_abort && !cur_ff.ctrl2[SEL_BIT] && cur_ff.bits >= ABORT_MIN_BITS)
    |=> cur_ff.flags[ABORT_UNDER_BIT])
    else $error("long abort not flagged");

  // (R8) Underrun flagged when selected
  a_underrun: assert property (@(posedge clk_in) disable iff (rst_in) // (R8)
    (ev_in.tx_empty_rd && cur_ff.ctrl2[SEL_BIT]) |=> cur_ff.flags[ABORT_UNDER_BIT])
    else $error("underrun not flagged");

  // (R5) Empty read sets bit 4
  a_empty_read: assert property (@(posedge clk_in) disable iff (rst_in) // (R5)
    ev_in.rx_empty_rd |=> cur_ff.flags[RX_LAST_BIT])
    else $error("empty read not flagged");

  // (R1) Go-ahead always recorded
  a_go_ahead_set: assert property (@(posedge clk_in) disable iff (rst_in) // (R1)
    ev_in.go_ahead |=> cur_ff.flags[GO_AHEAD_BIT])
    else $error("go-ahead not flagged");

  // (R2) Packet end byte recorded
  a_rx_end_set: assert property (@(posedge clk_in) disable iff (rst_in) // (R2)
    ev_in.rx_tag_wr |=> cur_ff.flags[RX_END_BIT])
    else $error("packet end not flagged");

  // (R6) Tx FIFO low recorded
  a_tx_low_set: assert property (@(posedge clk_in) disable iff (rst_in) // (R6)
    ev_in.tx_below_low |=> cur_ff.flags[TX_LOW_BIT])
    else $error("tx low not flagged");

  // (R9) Rx FIFO high recorded
  a_rx_high_set: assert property (@(posedge clk_in) disable iff (rst_in) // (R9)
    ev_in.rx_above_high |=> cur_ff.flags[RX_HIGH_BIT])
    else $error("rx high not flagged");

  // (R12) Flag edge turns the receiver back on unless it overflows again
  a_rx_reenable: assert property (@(posedge clk_in) disable iff (rst_in) // (R12)
    (flag_sync && !cur_ff.flag_prev && !ev_in.rx_full_wr) |=> rx_en_out)
    else $error("receiver not re-enabled");
endmodule

// ==== verification/host_model.sv ====
`timescale 1ns/1ns
// Host side of the parallel register port
module host_model (
  input wire logic clk_in,     // System clock
  output logic [7:0] addr_out, // Register address
  output logic rd_out,         // Read strobe
  output logic wr_out,         // Write strobe
  output logic [7:0] wdata_out // Write data
);
  // Idle bus at time zero
  initial
  begin
    addr_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end

  // One access, strobe held over exactly one sampling edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    rd_out <= ~w;
    wr_out <= w;
    @(posedge clk_in);
    rd_out <= 1'b0;
    wr_out <= 1'b0;
    // Released bus shows inverted value, so stale data cannot pass
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
endmodule

// ==== verification/hdlc_event_status_flags_tb.sv ====
`timescale 1ns/1ns
module hdlc_event_status_flags_tb
  import event_flags_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  events_t ev = '0;
  logic flag_pin = 1'b0;
  logic [7:0] rdata;
  logic irq_n;
  logic rx_en;
  logic rd_seen = 1'b0;
  logic [7:0] notes[$];
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  // Event field position and the flag bit it sets
  int evb[9] = '{11, 10, 9, 8, 0, 7, 5, 4, 3};
  int fb[9] = '{7, 6, 5, 4, 4, 3, 2, 1, 0};
  logic [7:0] m;

  host_model i_host_model (.clk_in(clk_in), .addr_out(addr), .rd_out(rd), .wr_out(wr),
    .wdata_out(wdata));
  hdlc_event_status_flags i_hdlc_event_status_flags (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata), .ev_in(ev),
    .flag_pin_in(flag_pin), .rdata_out(rdata), .irq_n_out(irq_n), .rx_en_out(rx_en));

  // Clock, 100 ns period
  initial
  begin
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    notes.push_back(e);
    i_host_model.acc(1'b0, a, 8'h00);
  endtask

  task automatic pulse(input events_t e);
    @(posedge clk_in);
    ev <= e;
    @(posedge clk_in);
    ev <= '0;
  endtask

  // Levels sampled mid-cycle, after updates settle
  task automatic lv(input logic i, input logic r);
    @(negedge clk_in);
    chk("irq_n", {7'h00, i}, {7'h00, irq_n});
    chk("rx_en", {7'h00, r}, {7'h00, rx_en});
  endtask

  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Read data lands one cycle after the read edge
  always @(posedge clk_in) rd_seen <= rd;
  always @(negedge clk_in)
  begin
    if (rd_seen === 1'b1 && notes.size() > 0)
      chk("rdata", notes.pop_front(), rdata);
  end

  // Hang guard, well above the run length
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      final_report();
    end
  end

  initial
  begin
    void'($urandom(32'hCE97));
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_exp(FLAGS_ADDR, FLAGS_RST);
    rd_exp(MASK_ADDR, MASK_RST);
    rd_exp(8'h40, 8'h00);
    lv(1'b1, 1'b1);
    $display("test reset done");
    i_host_model.acc(1'b1, CTRL2_ADDR, 8'h80);
    // Every source but the abort (select is high), alternately masked and unmasked
    for (int i = 0; i < 9; i++)
    begin
      m = i[0] ? 8'hFF : 8'($urandom()) & ~(8'h01 << fb[i]);
      i_host_model.acc(1'b1, MASK_ADDR, m);
      pulse(events_t'(12'h001 << evb[i]));
      lv(~m[fb[i]], i != 8);
      rd_exp(FLAGS_ADDR, 8'h01 << fb[i]);
      rd_exp(FLAGS_ADDR, 8'h00);
      lv(1'b1, i != 8);
    end
    $display("test sources done");
    pulse(events_t'(12'h008));
    rd_exp(FLAGS_ADDR, 8'h00);
    @(posedge clk_in);
    flag_pin <= 1'b1;
    repeat (6) @(posedge clk_in);
    lv(1'b1, 1'b1);
    pulse(events_t'(12'h008));
    rd_exp(FLAGS_ADDR, 8'h01);
    lv(1'b1, 1'b0);
    @(posedge clk_in);
    flag_pin <= 1'b0;
    $display("test overflow done");
    // Abort path needs select low and 26 bits
    i_host_model.acc(1'b1, CTRL2_ADDR, 8'h00);
    pulse(events_t'(12'h020));
    rd_exp(FLAGS_ADDR, 8'h00);
    pulse(events_t'(12'h004));
    for (int n = 25; n < 27; n++)
    begin
      repeat (n) pulse(events_t'(12'h002));
      pulse(events_t'(12'h040));
      rd_exp(FLAGS_ADDR, n == 26 ? 8'h04 : 8'h00);
    end
    $display("test abort done");
    // Event on the clearing read edge must survive
    notes.push_back(8'h00);
    fork
      i_host_model.acc(1'b0, FLAGS_ADDR, 8'h00);
      pulse(events_t'(12'h800));
    join
    rd_exp(FLAGS_ADDR, 8'h80);
    $display("test collision done");
    repeat (2) @(posedge clk_in);
    final_report();
  end
endmodule
